// ---- core/cdt_pkg.sv ----
// Constants shared by the countdown timer and its helper modules.
// Assumes a 12-bit APB byte address window with one 32-bit word per register.
package cdt_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_LOAD_VALUE   = 12'h400;
  localparam logic [11:0] OFS_CURRENT      = 12'h404;
  localparam logic [11:0] OFS_CONTROL      = 12'h408;
  localparam logic [11:0] OFS_IRQ_CLEAR    = 12'h40c;
  localparam logic [11:0] OFS_RAW_PENDING  = 12'h410;
  localparam logic [11:0] OFS_MASKED       = 12'h414;
  localparam logic [11:0] OFS_RELOAD       = 12'h418;
  localparam logic [11:0] OFS_TICK_DIVIDER = 12'h41c;
  localparam logic [11:0] OFS_FREE_COUNT   = 12'h420;

  // Control field positions
  localparam int CTL_WIDTH_BIT  = 1;
  localparam int CTL_PRE_LO     = 2;
  localparam int CTL_PRE_HI     = 3;
  localparam int CTL_IRQ_EN_BIT = 5;
  localparam int CTL_EN_BIT     = 7;
  localparam int CTL_DBG_BIT    = 8;
  localparam int CTL_FREE_EN    = 9;
  localparam int CTL_FDIV_LO    = 16;
  localparam int CTL_FDIV_HI    = 23;
  localparam int CLEAR_BIT      = 0;

  // Field widths
  localparam int TICK_DIV_W     = 10;
  localparam int FREE_DIV_W     = 8;
  localparam int PRE_CNT_W      = 8;

  // Reset values
  localparam logic [31:0]           RST_LOAD      = 32'h0000_0000;
  localparam logic [31:0]           RST_COUNT     = 32'h0000_0000;
  localparam logic                  RST_IRQ_EN    = 1'h1;
  localparam logic [1:0]            RST_PRE_SEL   = 2'h0;
  localparam logic                  RST_WIDTH     = 1'h0;
  localparam logic [TICK_DIV_W-1:0] RST_TICK_DIV  = 10'h07d;
  localparam logic [FREE_DIV_W-1:0] RST_FREE_DIV  = 8'h3e;

  // Fixed prescale selections
  localparam logic [1:0] PRE_DIV1   = 2'h0;
  localparam logic [1:0] PRE_DIV16  = 2'h1;
  localparam logic [1:0] PRE_DIV256 = 2'h2;
  localparam logic [PRE_CNT_W-1:0] PRE_LAST16  = 8'h0f;
  localparam logic [PRE_CNT_W-1:0] PRE_LAST256 = 8'hff;

  // Value read back from the write-only clear register; arbitrary value
  localparam logic [31:0] CLEAR_READ_VALUE = 32'h0000_0000;

endpackage : cdt_pkg

// ---- core/cdt_div.sv ----
// Programmable clock divider: one tick pulse every div+1 cycles while running.
// Assumes div is stable between ticks; a change takes effect at once, within the current period.
`timescale 1ns/1ps
module cdt_div #(
  parameter int W = 10
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         run,
  input  wire logic [W-1:0] div,
  output logic              tick
);
  logic [W-1:0] cnt;

  // Counter restarts when stopped so a fresh start begins a full period
  always_ff @(posedge ref_clk) begin
    if (rst || !run) begin
      cnt <= '0;
    end else if (cnt >= div) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + W'(1);
    end
  end

  assign tick = run && (cnt >= div); // Wraps early if div shrinks mid-period
endmodule // cdt_div

// ---- core/cdt_pre.sv ----
// Fixed prescaler: passes every 1st, 16th or 256th input tick.
// Assumes tick_in is a one-cycle pulse from the programmable divider.
`timescale 1ns/1ps
module cdt_pre
  import cdt_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       tick_in,
  input  wire logic [1:0] sel,
  output logic            tick_out
);
  logic [PRE_CNT_W-1:0] cnt;

  // Count base ticks; wraps naturally at 256, or clears after 16 ticks when divide by 16 is selected
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt <= '0;
    end else if (tick_in) begin
      cnt <= (sel == PRE_DIV16 && cnt[3:0] == PRE_LAST16[3:0]) ? '0 : cnt + 8'h01;
    end
  end

  // Select 11 behaves as divide by one
  always_comb begin
    unique case (sel)
      PRE_DIV16:  tick_out = tick_in && (cnt[3:0] == PRE_LAST16[3:0]);
      PRE_DIV256: tick_out = tick_in && (cnt == PRE_LAST256);
      default:    tick_out = tick_in;
    endcase
  end
endmodule // cdt_pre

// ---- core/cdt_timer.sv ----
// Countdown timer with reload, prescaling and a free-running up-counter.
// Assumes an APB master on ref_clk and a debug-halt level synchronous to it.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
// How it works
// - One down-counter, periodic mode only
// - Load write copies value into count
// - Enable bit 7 decrements per tick
// - At zero reload and set pending
// - Count register 32-bit, read-only, resets zero
// - Prescale bits 3:2 divide 1/16/256/1
// - Bit 1 selects 16 or 32 bits
// - Bit 5 gates pending onto interrupt
// - Bit 8 stops both counters in halt
// - Bit 9 enables free counter, resets zero
// - Free tick is clock over field+1
// - Registers from 0x400 to 0x420
// - Timer tick is clock over divider+1
// - Interrupt equals pending AND enable
// - Writing one to clear bit clears pending
// - Free counter wraps, cannot be reset
module cdt_timer
  import cdt_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        debug_halt,
  output logic             irq
);
  // Register state
  logic [31:0]           load_value;
  logic [31:0]           current_count;
  logic [31:0]           free_running_count;
  logic                  pending;
  logic                  timer_enable;
  logic                  interrupt_enable_bit;
  logic [1:0]            prescale_sel;
  logic                  counter_width_select;
  logic                  stop_in_debug;
  logic                  free_counter_enable;
  logic [FREE_DIV_W-1:0] free_counter_prescale;
  logic [TICK_DIV_W-1:0] tick_divider_value;

  // Internal strobes and ticks
  logic        acc_wr;
  logic        acc_setup_done;
  logic        halted;
  logic        timer_run;
  logic        free_run;
  logic        base_tick;
  logic        timer_tick;
  logic        free_tick;
  logic [31:0] count_view;
  logic        count_zero;
  logic        load_wr;
  logic        clear_wr;
  logic        ctl_wr;
  logic        next_pending;
  logic        next_irq_en;
  logic [31:0] rd_mux;
  logic        addr_hit;

  // APB: write lands at the edge that completes the transfer
  assign acc_wr         = psel && penable && pready && pwrite;
  assign acc_setup_done = psel && penable && !pready;
  assign load_wr        = acc_wr && (paddr == OFS_LOAD_VALUE);
  assign clear_wr       = acc_wr && (paddr == OFS_IRQ_CLEAR) && pwdata[CLEAR_BIT];
  assign ctl_wr         = acc_wr && (paddr == OFS_CONTROL);

  // Halt only gates counting; registers stay accessible while halted
  assign halted    = stop_in_debug && debug_halt;
  assign timer_run = timer_enable && !halted;
  assign free_run  = free_counter_enable && !halted;

  // Programmable base divider for the timer
  cdt_div #(
    .W (TICK_DIV_W)
  ) u_tick_div (
    .ref_clk (ref_clk),
    .rst     (rst),
    .run     (timer_run),
    .div     (tick_divider_value),
    .tick    (base_tick)
  );

  // Fixed prescale after the base divider
  cdt_pre u_pre (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .tick_in  (base_tick),
    .sel      (prescale_sel),
    .tick_out (timer_tick)
  );

  // Own divider for the free-running counter
  cdt_div #(
    .W (FREE_DIV_W)
  ) u_free_div (
    .ref_clk (ref_clk),
    .rst     (rst),
    .run     (free_run),
    .div     (free_counter_prescale),
    .tick    (free_tick)
  );

  // Upper half is ignored in 16-bit mode for both counting and zero test
  assign count_view = counter_width_select ? current_count
                                           : {16'h0000, current_count[15:0]};
  assign count_zero = (count_view == 32'h0000_0000);

  // Down-counter; periodic only, so zero always reloads
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      current_count <= RST_COUNT;
    end else if (load_wr) begin
      current_count <= pwdata;
    end else if (timer_run && timer_tick) begin
      if (count_zero) begin
        current_count <= load_value;
      end else begin
        current_count <= count_view - 32'h0000_0001;
      end
    end
  end

  // Load value written by either load or reload register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      load_value <= RST_LOAD;
    end else if (acc_wr && (paddr == OFS_LOAD_VALUE || paddr == OFS_RELOAD)) begin
      load_value <= pwdata;
    end
  end

  // Set wins over a clear arriving in the same cycle
  always_comb begin
    next_pending = pending;
    if (clear_wr) begin
      next_pending = 1'b0;
    end
    if (timer_run && timer_tick && count_zero) begin
      next_pending = 1'b1;
    end
    next_irq_en = ctl_wr ? pwdata[CTL_IRQ_EN_BIT] : interrupt_enable_bit;
  end

  // Pending flag and interrupt line kept in step
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pending <= 1'b0;
      irq     <= 1'b0;
    end else begin
      pending <= next_pending;
      irq     <= next_pending && next_irq_en;
    end
  end

  // Control fields
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      timer_enable          <= 1'b0;
      interrupt_enable_bit  <= RST_IRQ_EN;
      prescale_sel          <= RST_PRE_SEL;
      counter_width_select  <= RST_WIDTH;
      stop_in_debug         <= 1'b0;
      free_counter_enable   <= 1'b0;
      free_counter_prescale <= RST_FREE_DIV;
    end else if (ctl_wr) begin
      timer_enable          <= pwdata[CTL_EN_BIT];
      interrupt_enable_bit  <= next_irq_en;
      prescale_sel          <= pwdata[CTL_PRE_HI:CTL_PRE_LO];
      counter_width_select  <= pwdata[CTL_WIDTH_BIT];
      stop_in_debug         <= pwdata[CTL_DBG_BIT];
      free_counter_enable   <= pwdata[CTL_FREE_EN];
      free_counter_prescale <= pwdata[CTL_FDIV_HI:CTL_FDIV_LO];
    end
  end

  // Tick divider register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tick_divider_value <= RST_TICK_DIV;
    end else if (acc_wr && paddr == OFS_TICK_DIVIDER) begin
      tick_divider_value <= pwdata[TICK_DIV_W-1:0];
    end
  end

  // Free counter: no write path, so software cannot reset it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      free_running_count <= 32'h0000_0000;
    end else if (free_run && free_tick) begin
      free_running_count <= free_running_count + 32'h0000_0001;
    end
  end

  // Read decode; unmapped words read zero and flag an error
  always_comb begin
    rd_mux   = 32'h0000_0000;
    addr_hit = 1'b1;
    unique case (paddr)
      OFS_LOAD_VALUE, OFS_RELOAD: rd_mux = load_value;
      OFS_CURRENT:      rd_mux = count_view;
      OFS_CONTROL: begin
        rd_mux[CTL_WIDTH_BIT]           = counter_width_select;
        rd_mux[CTL_PRE_HI:CTL_PRE_LO]   = prescale_sel;
        rd_mux[CTL_IRQ_EN_BIT]          = interrupt_enable_bit;
        rd_mux[CTL_EN_BIT]              = timer_enable;
        rd_mux[CTL_DBG_BIT]             = stop_in_debug;
        rd_mux[CTL_FREE_EN]             = free_counter_enable;
        rd_mux[CTL_FDIV_HI:CTL_FDIV_LO] = free_counter_prescale;
      end
      OFS_IRQ_CLEAR:    rd_mux = CLEAR_READ_VALUE;
      OFS_RAW_PENDING:  rd_mux[CLEAR_BIT] = pending;
      OFS_MASKED:       rd_mux[CLEAR_BIT] = pending && interrupt_enable_bit;
      OFS_TICK_DIVIDER: rd_mux[TICK_DIV_W-1:0] = tick_divider_value;
      OFS_FREE_COUNT:   rd_mux = free_running_count;
      default:          addr_hit = 1'b0;
    endcase
  end

  // One wait state: data and error registered at the same edge as pready
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc_setup_done;
      pslverr <= acc_setup_done && !addr_hit;
      if (acc_setup_done && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  irq_gate_a: assert property (irq == (pending && interrupt_enable_bit))
    else $error("irq differs from pending and enable");

  load_copy_a: assert property (load_wr |=> current_count == $past(pwdata))
    else $error("load write not copied into count");

  zero_reload_a: assert property (
    (timer_run && timer_tick && count_zero && !load_wr)
    |=> (pending && current_count == $past(load_value)))
    else $error("zero did not reload and set pending");

  count_hold_a: assert property ((!timer_run && !load_wr) |=> $stable(current_count))
    else $error("count moved while stopped");

  count_step_a: assert property (
    (timer_run && timer_tick && !count_zero && !load_wr)
    |=> current_count == $past(count_view) - 32'h0000_0001)
    else $error("count did not step down by one");

  clear_pend_a: assert property (
    (clear_wr && !(timer_run && timer_tick && count_zero)) |=> !pending)
    else $error("clear did not drop pending");

  set_wins_a: assert property ((clear_wr && timer_run && timer_tick && count_zero)
    |=> pending)
    else $error("set lost against clear");

  free_hold_a: assert property (!free_run |=> $stable(free_running_count))
    else $error("free counter moved while stopped");

  halt_stop_a: assert property ((stop_in_debug && debug_halt && !load_wr)
    |=> $stable(current_count))
    else $error("timer ran in debug halt");

  reload_only_a: assert property ((acc_wr && paddr == OFS_RELOAD && !timer_run)
    |=> $stable(current_count))
    else $error("reload write forced a reload");

  apb_wait_a: assert property (acc_setup_done |=> pready ##1 !pready)
    else $error("pready not one cycle after access");

  // Control fields follow the completing write one edge later
  enable_cap_a: assert property (
    ctl_wr |=> timer_enable == $past(pwdata[CTL_EN_BIT]))
    else $error("enable bit not taken from control write");

  irq_en_cap_a: assert property (
    ctl_wr |=> interrupt_enable_bit == $past(pwdata[CTL_IRQ_EN_BIT]))
    else $error("interrupt enable not taken from control write");

  width_cap_a: assert property (
    ctl_wr |=> counter_width_select == $past(pwdata[CTL_WIDTH_BIT]))
    else $error("width select not taken from control write");

  prescale_cap_a: assert property (
    ctl_wr |=> prescale_sel == $past(pwdata[CTL_PRE_HI:CTL_PRE_LO]))
    else $error("prescale select not taken from control write");

  halt_cap_a: assert property (
    ctl_wr |=> stop_in_debug == $past(pwdata[CTL_DBG_BIT]))
    else $error("debug stop bit not taken from control write");

  free_en_cap_a: assert property (
    ctl_wr |=> free_counter_enable == $past(pwdata[CTL_FREE_EN]))
    else $error("free counter enable not taken from control write");

  free_div_cap_a: assert property (
    ctl_wr |=> free_counter_prescale == $past(pwdata[CTL_FDIV_HI:CTL_FDIV_LO]))
    else $error("free counter divider not taken from control write");

  // Tick divider keeps only its ten low bits
  tick_div_cap_a: assert property (
    (acc_wr && paddr == OFS_TICK_DIVIDER)
    |=> tick_divider_value == $past(pwdata[TICK_DIV_W-1:0]))
    else $error("tick divider not taken from its write");

  // Free counter steps by exactly one per tick and wraps at the top
  free_step_a: assert property (
    (free_run && free_tick) |=> free_running_count == $past(free_running_count) + 32'h0000_0001)
    else $error("free counter did not step by one");

  // Read-only words ignore writes
  count_ro_a: assert property (
    (acc_wr && paddr == OFS_CURRENT && !timer_run) |=> $stable(current_count))
    else $error("write to current count changed it");

  free_ro_a: assert property (
    (acc_wr && paddr == OFS_FREE_COUNT && !free_run) |=> $stable(free_running_count))
    else $error("write to free count changed it");

  // Pending moves only on a zero tick or a clear
  pend_hold_a: assert property (
    (!clear_wr && !(timer_run && timer_tick && count_zero)) |=> pending == $past(pending))
    else $error("pending changed with no cause");

  // Error answer only for unmapped words; address is held through the access
  slverr_map_a: assert property (
    pready |-> pslverr == !addr_hit)
    else $error("error answer does not match the address map");

endmodule // cdt_timer

// ---- tb/tb.sv ----
// Self-checking bench for the countdown timer, driven over APB.
// Assumes cdt_timer answers each access one cycle after the first access cycle.
`timescale 1ns/1ps
module tb;
  import cdt_pkg::*;
  logic        ref_clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        debug_halt;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [31:0] rd;
  logic [31:0] a;
  logic        er;
  int          n_mismatch = 0;
  int          checks = 0;
  int          cyc = 0;
  int          d;
  // Control value after reset: interrupt enable set, free divider 0x3e
  localparam logic [31:0] CTL = 32'h003e_0020;

  cdt_timer dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .debug_halt(debug_halt), .irq(irq));

  // 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // One APB transfer; pready is read at each rising edge before the design updates it,
  // and only the hang guard ends a wait that never completes
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) begin
      @(posedge ref_clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] v);
    apb(1'b1, ad, v);
  endtask

  task automatic rchk(input logic [11:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    chk(rd, exp);
  endtask

  function automatic logic [31:0] inr(input logic [31:0] v, lo, hi);
    return {31'h0, (v >= lo && v <= hi)};
  endfunction

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    debug_halt = 1'b0;
    void'($urandom(41));
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    // Reset values
    rchk(OFS_CONTROL, CTL);
    rchk(OFS_TICK_DIVIDER, 32'h0000_007d);
    rchk(OFS_CURRENT, 32'h0);
    rchk(OFS_FREE_COUNT, 32'h0);
    rchk(OFS_RAW_PENDING, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // Unmapped places answer with an error and read zero
    apb(1'b1, 12'h424, 32'hffff_ffff);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 12'h3fc, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000);
    rchk(OFS_IRQ_CLEAR, CLEAR_READ_VALUE);
    // Load copies into count; count ignores writes; reload shares the value
    wr(OFS_CONTROL, CTL | 32'h2);
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 32'hffff_ffff : $urandom();
      wr(OFS_LOAD_VALUE, a);
      rchk(OFS_CURRENT, a);
      wr(OFS_CURRENT, ~a);
      rchk(OFS_CURRENT, a);
      rchk(OFS_RELOAD, a);
    end
    // Reload write waits for the next zero
    wr(OFS_LOAD_VALUE, 32'd100);
    wr(OFS_RELOAD, 32'd50);
    rchk(OFS_CURRENT, 32'd100);
    wr(OFS_TICK_DIVIDER, 32'h0);
    wr(OFS_CONTROL, CTL | 32'h82);
    repeat (150) @(posedge ref_clk);
    wr(OFS_CONTROL, CTL | 32'h2);
    apb(1'b0, OFS_CURRENT, 32'h0);
    chk(inr(rd, 0, 50), 32'h1);
    rchk(OFS_RAW_PENDING, 32'h1);
    // Tick rate for every prescale code, then a divider of 3
    for (int s = 0; s < 5; s++) begin
      d = (s == 1) ? 16 : (s == 2) ? 256 : (s == 4) ? 4 : 1;
      wr(OFS_TICK_DIVIDER, (s == 4) ? 32'h3 : 32'h0);
      wr(OFS_LOAD_VALUE, 32'h0000_ffff);
      wr(OFS_CONTROL, CTL | 32'h82 | ((s & 3) << 2));
      repeat (512) @(posedge ref_clk);
      wr(OFS_CONTROL, CTL | 32'h2);
      apb(1'b0, OFS_CURRENT, 32'h0);
      chk(inr(rd, 32'hffff - 512 / d - 8, 32'hffff - 512 / d + 1), 32'h1);
      rchk(OFS_CURRENT, rd);
    end
    // Sixteen-bit zero detect, pending, masking and clearing
    wr(OFS_TICK_DIVIDER, 32'h0);
    wr(OFS_IRQ_CLEAR, 32'h1);
    wr(OFS_CONTROL, CTL);
    wr(OFS_LOAD_VALUE, 32'habcd_0003);
    rchk(OFS_CURRENT, 32'h0000_0003);
    wr(OFS_CONTROL, CTL | 32'h80);
    repeat (8) @(posedge ref_clk);
    wr(OFS_CONTROL, CTL);
    rchk(OFS_RAW_PENDING, 32'h1);
    rchk(OFS_MASKED, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_IRQ_CLEAR, 32'hffff_fffe);
    rchk(OFS_RAW_PENDING, 32'h1);
    wr(OFS_CONTROL, CTL & ~32'h20);
    rchk(OFS_MASKED, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_IRQ_CLEAR, 32'h1);
    rchk(OFS_RAW_PENDING, 32'h0);
    // Free counter at divide by 1, then by 4
    for (int k = 0; k < 2; k++) begin
      wr(OFS_CONTROL, (k == 0) ? 32'h0000_0220 : 32'h0003_0220);
      apb(1'b0, OFS_FREE_COUNT, 32'h0);
      a = rd;
      repeat (196) @(posedge ref_clk);
      apb(1'b0, OFS_FREE_COUNT, 32'h0);
      chk(inr(rd - a, (k == 0) ? 198 : 48, (k == 0) ? 206 : 53), 32'h1);
    end
    // Debug halt stops both counters when asked to; the free counter runs on when not asked
    wr(OFS_LOAD_VALUE, 32'h0000_ffff);
    @(posedge ref_clk);
    debug_halt <= 1'b1;
    wr(OFS_CONTROL, 32'h0003_03a2);
    apb(1'b0, OFS_FREE_COUNT, 32'h0);
    a = rd;
    rchk(OFS_FREE_COUNT, a);
    apb(1'b0, OFS_CURRENT, 32'h0);
    rchk(OFS_CURRENT, rd);
    wr(OFS_CONTROL, 32'h0003_02a2);
    // Divider restarts from zero, so give it a few periods before looking
    repeat (8) @(posedge ref_clk);
    apb(1'b0, OFS_FREE_COUNT, 32'h0);
    chk(inr(rd - a, 1, 20), 32'h1);
    @(posedge ref_clk);
    debug_halt <= 1'b0;
    // Free counter stops when its enable is cleared
    wr(OFS_CONTROL, 32'h0003_0020);
    apb(1'b0, OFS_FREE_COUNT, 32'h0);
    rchk(OFS_FREE_COUNT, rd);
    end_of_test();
  end
endmodule // tb
